// File: hw/tcc_params.svh
// Purpose: Constants of the timer capture/compare block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes: Status bits are write-one-to-clear
//
// How it works
// R1: Flag encoder inputs changing both bits together
// R2: Transition error can raise the interrupt
// R3: Flag full counter sweep without index
// R4: Index position error can raise the interrupt
// R5: Overflow/underflow gives update event and trigger
// R6: Each compare channel makes its own event
// R7: Channels 1-4 each configurable as capture
// R8: Neighbour input or link source feeds capture
// R9: Capture edge: rising, falling or both
// R10: Capture once per 1, 2, 4, 8 events
// R11: Filter needs N equal samples; glitch restarts
// R12: Capture copies counter, flags, may interrupt
// R13: Unread capture overwritten sets overcapture flag
// R14: Clear-on-capture zeroes counter after capture
// R15: PWM input: ch2 rising period, ch1 falling
// R16: XOR of three inputs, every edge captures
// R17: Compare match sets, resets, toggles or holds
// R18: Match sets flag; interrupt only when enabled
// R19: Preloaded compare loads at update, else immediately
// R20: Output mode also optionally preloaded
// R21: Trigger starts counter, single or repetitive pulse
// R22: Retrigger restarts pulse timing
// R23: Index clears counter up, loads reload down
// R24: Update moves preloads into active registers
// R25: Encoder state checked against previous every cycle
// R26: Index event re-arms position check
// R27: Flags sticky; interrupt while flag and enable
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH
`define TCC_OFF_CTRL 6'h00
`define TCC_OFF_SR 6'h04
`define TCC_OFF_IER 6'h08
`define TCC_OFF_CNT 6'h0C
`define TCC_OFF_ARR 6'h10
`define TCC_OFF_CFG 6'h14
`define TCC_OFF_CCR 6'h1C
`define TCC_CR_EN 0
`define TCC_CR_DIR 1
`define TCC_CR_ARPE 2
`define TCC_CR_OPM 3
`define TCC_CR_RETRIG 4
`define TCC_CR_REPT 5
`define TCC_CR_XOR 6
`define TCC_CR_COC 7
`define TCC_CR_ENC 8
`define TCC_CR_IDX 9
`define TCC_CR_PWMI 10
`define TCC_CR_FILT 12
`define TCC_CR_LINK 16
`define TCC_SR_UIF 0
`define TCC_SR_CC 1
`define TCC_SR_OVR 5
`define TCC_SR_TERR 9
`define TCC_SR_IERR 10
`define TCC_CTRL_RST 32'h0000_0000
`define TCC_ARR_RST 16'hFFFF
`define TCC_CFG_RST 16'h0000
`define TCC_SRC_NEIGH 2'h1
`define TCC_SRC_LINK 2'h2
`define TCC_EDG_RISE 2'h0
`define TCC_EDG_FALL 2'h1
`define TCC_EDG_BOTH 2'h2
`endif

// File: hw/tcc_pkg.sv
// Purpose: Types of the timer capture/compare block
// Assumes: Constants live in tcc_params.svh
// Notes: Channel config is one 16-bit half word
package tcc_pkg;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK = 2'b01
   } tcc_bus_t;
   typedef enum logic [1:0] {
      OCM_FROZEN = 2'b00,
      OCM_SET = 2'b01,
      OCM_RESET = 2'b10,
      OCM_TOGGLE = 2'b11
   } tcc_ocm_t;
   typedef struct packed {
      logic [4:0] spare;
      logic oc_mpre;
      logic oc_cpre;
      tcc_ocm_t oc_mode;
      logic [1:0] psc;
      logic [1:0] edg;
      logic [1:0] src;
      logic is_cap;
   } tcc_chcfg_t;
endpackage

// File: hw/tcc_top.sv
// Purpose: Capture/compare channels, encoder error checks, time base
// Assumes: Pins asynchronous; link inputs on sys_clk_in
// Notes: One wait state on every bus access
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns
`include "tcc_params.svh"
module tcc_top (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // Avalon-MM slave
   input wire logic [5:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Input pins
   input wire logic [3:0] ch_in,
   input wire logic enc_index_in,
   input wire logic trig_in,
   // Same-clock links from other timers
   input wire logic [3:0] timer_link_input_in,
   // Outputs
   output logic [3:0] oc_out,
   output logic update_trig_out,
   output logic [3:0] cmp_trig_out,
   output logic irq_out
);
   function automatic logic [31:0] tcc_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [2:0] tcc_psc_lim(input logic [1:0] p);
      case (p)
         2'h0: return 3'h0;
         2'h1: return 3'h1;
         2'h2: return 3'h3;
         default: return 3'h7;
      endcase
   endfunction

   tcc_pkg::tcc_bus_t bus_q;
   logic wreq_q;
   logic [31:0] rdata_q;
   logic [31:0] ctrl_q;
   logic [10:0] sr_q;
   logic [10:0] ier_q;
   logic [15:0] cnt_q;
   logic [15:0] arr_pre_q;
   logic [15:0] arr_q;
   tcc_pkg::tcc_chcfg_t cfg_q [4];
   logic [15:0] ccr_pre_q [4];
   logic [15:0] ccr_q [4];
   tcc_pkg::tcc_ocm_t ocm_q [4];
   logic [2:0] psc_q [4];
   logic [5:0] pin_s1_q;
   logic [5:0] pin_s2_q;
   logic [5:0] flt_q;
   logic [5:0] flt_prev_q;
   logic [3:0] fcnt_q [6];
   logic [3:0] lvl_prev_q;
   logic seen_q;
   logic [3:0] oc_q;
   logic upd_out_q;
   logic [3:0] cmp_q;
   logic irq_q;

   // Bus decode
   wire acc_w = (avs_read_in || avs_write_in) && bus_q == tcc_pkg::BUS_IDLE;
   wire we_w = avs_write_in && bus_q == tcc_pkg::BUS_ACK;
   wire re_w = avs_read_in && bus_q == tcc_pkg::BUS_ACK;
   wire [5:0] adr_w = avs_address_in;
   wire [31:0] wd_w = avs_writedata_in;
   wire [3:0] be_w = avs_byteenable_in;
   wire wr_ctrl_w = we_w && adr_w == `TCC_OFF_CTRL;
   wire wr_sr_w = we_w && adr_w == `TCC_OFF_SR;
   wire wr_ier_w = we_w && adr_w == `TCC_OFF_IER;
   wire wr_cnt_w = we_w && adr_w == `TCC_OFF_CNT;
   wire wr_arr_w = we_w && adr_w == `TCC_OFF_ARR;

   // Control fields
   wire run_w = ctrl_q[`TCC_CR_EN];
   wire dir_w = ctrl_q[`TCC_CR_DIR];
   wire opm_w = ctrl_q[`TCC_CR_OPM];
   wire xor_w = ctrl_q[`TCC_CR_XOR];
   wire pwmi_w = ctrl_q[`TCC_CR_PWMI];
   wire idx_en_w = ctrl_q[`TCC_CR_IDX];
   wire [3:0] filt_len_w = ctrl_q[`TCC_CR_FILT +: 4];
   wire lnk_w = timer_link_input_in[ctrl_q[`TCC_CR_LINK +: 2]];
   wire [31:0] ctrl_m_w = tcc_merge(ctrl_q, wd_w, be_w);
   wire [31:0] cnt_m_w = tcc_merge({16'h0000, cnt_q}, wd_w, be_w);
   wire [31:0] arr_m_w = tcc_merge({16'h0000, arr_pre_q}, wd_w, be_w);

   // Pin events after filter
   wire xor_lvl_w = flt_q[0] ^ flt_q[1] ^ flt_q[2]; // [R16]
   wire qerr_w = ctrl_q[`TCC_CR_ENC] && ((flt_q[1:0] ^ flt_prev_q[1:0]) == 2'h3); // [R1] [R25]
   wire idx_ev_w = flt_q[4] && !flt_prev_q[4];
   wire trg_ev_w = flt_q[5] && !flt_prev_q[5];
   wire retrig_w = opm_w && ctrl_q[`TCC_CR_RETRIG] && trg_ev_w && run_w; // [R22]

   // Time base
   wire upd_w = run_w && (dir_w ? cnt_q == 16'h0000 : cnt_q == arr_q); // [R5]
   wire start_w = dir_w ? cnt_q == arr_q : cnt_q == 16'h0000;
   wire ierr_w = idx_en_w && upd_w && seen_q && !idx_ev_w; // [R3]
   wire [15:0] wrap_w = dir_w ? arr_q : 16'h0000;

   logic [3:0] lvl_w;
   logic [3:0] cap_w;
   logic [3:0] match_w;
   logic [3:0] ccr_hit_w;
   logic [3:0] psc_hit_w;
   logic [3:0] capmode_w;
   logic [3:0] ev_w;
   logic [31:0] cfg_m_w [4];

   for (genvar g = 0; g < 4; g++) begin : g_ch
      localparam int P = (g / 2) * 2;
      localparam int SH = (g % 2) * 16;
      wire pw_w = pwmi_w && g < 2;
      wire own_w = (g == 0 && xor_w) ? xor_lvl_w : flt_q[g];
      wire nb_w = flt_q[g ^ 1];
      wire [1:0] src_w = pw_w ? (g == 0 ? 2'h0 : `TCC_SRC_NEIGH) : cfg_q[g].src; // [R15]
      wire [1:0] edg_w = pw_w ? (g == 0 ? `TCC_EDG_FALL : `TCC_EDG_RISE) :
         (g == 0 && xor_w) ? `TCC_EDG_BOTH : cfg_q[g].edg; // [R16]
      wire rise_w = lvl_w[g] && !lvl_prev_q[g];
      wire fall_w = !lvl_w[g] && lvl_prev_q[g];
      assign lvl_w[g] = src_w == `TCC_SRC_LINK ? lnk_w :
         src_w == `TCC_SRC_NEIGH ? nb_w : own_w; // [R8]
      assign ev_w[g] = (rise_w && edg_w != `TCC_EDG_FALL) ||
         (fall_w && edg_w != `TCC_EDG_RISE); // [R9]
      assign capmode_w[g] = cfg_q[g].is_cap || pw_w || (g == 0 && xor_w); // [R7]
      assign psc_hit_w[g] = psc_q[g] == tcc_psc_lim(cfg_q[g].psc); // [R10]
      assign cap_w[g] = capmode_w[g] && ev_w[g] && psc_hit_w[g];
      assign match_w[g] = !capmode_w[g] && run_w && cnt_q == ccr_q[g]; // [R6]
      assign ccr_hit_w[g] = adr_w == 6'(`TCC_OFF_CCR + 4 * g);
      assign cfg_m_w[g] = tcc_merge({cfg_q[P + 1], cfg_q[P]}, wd_w, be_w);

      always_ff @(posedge sys_clk_in) begin
         if (!resetn_in) begin
            cfg_q[g] <= `TCC_CFG_RST;
            ccr_pre_q[g] <= 16'h0000;
            ccr_q[g] <= 16'h0000;
            ocm_q[g] <= tcc_pkg::OCM_FROZEN;
            psc_q[g] <= 3'h0;
         end else begin
            if (we_w && adr_w == 6'(`TCC_OFF_CFG + 4 * (g / 2))) begin
               cfg_q[g] <= cfg_m_w[g][SH +: 16];
            end
            if (we_w && ccr_hit_w[g]) begin
               ccr_pre_q[g] <= 16'(tcc_merge({16'h0000, ccr_pre_q[g]}, wd_w, be_w));
            end
            if (cap_w[g]) begin
               ccr_q[g] <= cnt_q; // [R12]
            end else if (we_w && ccr_hit_w[g] && !cfg_q[g].oc_cpre) begin
               ccr_q[g] <= 16'(tcc_merge({16'h0000, ccr_q[g]}, wd_w, be_w)); // [R19]
            end else if (upd_w && cfg_q[g].oc_cpre) begin
               ccr_q[g] <= ccr_pre_q[g]; // [R19] [R24]
            end
            if (!cfg_q[g].oc_mpre || upd_w) begin
               ocm_q[g] <= cfg_q[g].oc_mode; // [R20] [R24]
            end
            if (!capmode_w[g]) begin
               psc_q[g] <= 3'h0;
            end else if (ev_w[g]) begin
               psc_q[g] <= psc_hit_w[g] ? 3'h0 : psc_q[g] + 3'h1; // [R10]
            end
         end
      end
   end

   // Counter clear sources: captures and retrigger
   wire clr_w = ((ctrl_q[`TCC_CR_COC] || xor_w) && |cap_w) ||
      (pwmi_w && cap_w[1]) || retrig_w; // [R14] [R15] [R16] [R22]

   // Status: hardware set wins over software clear
   logic [10:0] set_w;
   logic [10:0] clr_sr_w;
   logic [10:0] sr_d;
   logic [3:0] rd_ccr_w;
   assign rd_ccr_w = re_w ? ccr_hit_w : 4'h0;
   assign set_w[`TCC_SR_UIF] = upd_w;
   assign set_w[`TCC_SR_CC +: 4] = cap_w | match_w; // [R12] [R18]
   assign set_w[`TCC_SR_OVR +: 4] = cap_w & sr_q[`TCC_SR_CC +: 4]; // [R13]
   assign set_w[`TCC_SR_TERR] = qerr_w; // [R1]
   assign set_w[`TCC_SR_IERR] = ierr_w; // [R3]
   assign clr_sr_w = (wr_sr_w ? wd_w[10:0] : 11'h000) | {6'h00, rd_ccr_w, 1'b0};
   assign sr_d = (sr_q & ~clr_sr_w) | set_w; // [R27]

   // Read mux
   logic [31:0] rmux_w;
   always_comb begin
      case (adr_w)
         `TCC_OFF_CTRL: rmux_w = ctrl_q;
         `TCC_OFF_SR: rmux_w = {21'h0, sr_q};
         `TCC_OFF_IER: rmux_w = {21'h0, ier_q};
         `TCC_OFF_CNT: rmux_w = {16'h0000, cnt_q};
         `TCC_OFF_ARR: rmux_w = {16'h0000, arr_pre_q};
         6'h14: rmux_w = {cfg_q[1], cfg_q[0]};
         6'h18: rmux_w = {cfg_q[3], cfg_q[2]};
         6'h1C: rmux_w = {16'h0000, ccr_q[0]};
         6'h20: rmux_w = {16'h0000, ccr_q[1]};
         6'h24: rmux_w = {16'h0000, ccr_q[2]};
         6'h28: rmux_w = {16'h0000, ccr_q[3]};
         default: rmux_w = 32'h0000_0000;
      endcase
   end

   // Bus handshake, one wait state
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         bus_q <= tcc_pkg::BUS_IDLE;
         wreq_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         case (bus_q)
            tcc_pkg::BUS_IDLE: bus_q <= acc_w ? tcc_pkg::BUS_ACK : tcc_pkg::BUS_IDLE;
            tcc_pkg::BUS_ACK: bus_q <= tcc_pkg::BUS_IDLE;
            default: bus_q <= tcc_pkg::BUS_IDLE;
         endcase
         wreq_q <= !acc_w;
         if (acc_w && avs_read_in) begin
            rdata_q <= rmux_w;
         end
      end
   end

   // Pin synchronisers and filters
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         pin_s1_q <= 6'h00;
         pin_s2_q <= 6'h00;
         flt_q <= 6'h00;
         flt_prev_q <= 6'h00;
         lvl_prev_q <= 4'h0;
         for (int i = 0; i < 6; i++) begin
            fcnt_q[i] <= 4'h0;
         end
      end else begin
         pin_s1_q <= {trig_in, enc_index_in, ch_in};
         pin_s2_q <= pin_s1_q;
         flt_prev_q <= flt_q;
         lvl_prev_q <= lvl_w;
         for (int i = 0; i < 6; i++) begin
            if (pin_s2_q[i] == flt_q[i]) begin
               fcnt_q[i] <= 4'h0; // [R11]
            end else if (fcnt_q[i] + 4'h1 >= filt_len_w) begin
               flt_q[i] <= pin_s2_q[i]; // [R11]
               fcnt_q[i] <= 4'h0;
            end else begin
               fcnt_q[i] <= fcnt_q[i] + 4'h1;
            end
         end
      end
   end

   // Control, counter, status
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         ctrl_q <= `TCC_CTRL_RST;
         ier_q <= 11'h000;
         cnt_q <= 16'h0000;
         arr_pre_q <= `TCC_ARR_RST;
         arr_q <= `TCC_ARR_RST;
         sr_q <= 11'h000;
         seen_q <= 1'b0;
      end else begin
         sr_q <= sr_d;
         if (wr_ier_w) begin
            ier_q <= 11'(tcc_merge({21'h0, ier_q}, wd_w, be_w));
         end
         if (opm_w && trg_ev_w) begin
            ctrl_q <= (wr_ctrl_w ? ctrl_m_w : ctrl_q) | 32'h1; // [R21]
         end else if (opm_w && upd_w && !ctrl_q[`TCC_CR_REPT]) begin
            ctrl_q <= (wr_ctrl_w ? ctrl_m_w : ctrl_q) & ~32'h1; // [R21]
         end else if (wr_ctrl_w) begin
            ctrl_q <= ctrl_m_w;
         end
         if (wr_arr_w) begin
            arr_pre_q <= arr_m_w[15:0];
         end
         if (wr_arr_w && !ctrl_q[`TCC_CR_ARPE]) begin
            arr_q <= arr_m_w[15:0];
         end else if (upd_w && ctrl_q[`TCC_CR_ARPE]) begin
            arr_q <= arr_pre_q; // [R24]
         end
         if (wr_cnt_w) begin
            cnt_q <= cnt_m_w[15:0];
         end else if (clr_w) begin
            cnt_q <= 16'h0000; // [R14] [R22]
         end else if (idx_en_w && idx_ev_w) begin
            cnt_q <= wrap_w; // [R23]
         end else if (run_w) begin
            cnt_q <= upd_w ? wrap_w : (dir_w ? cnt_q - 16'h1 : cnt_q + 16'h1); // [R5]
         end
         if (idx_ev_w) begin
            seen_q <= 1'b0; // [R26]
         end else if (run_w && start_w) begin
            seen_q <= 1'b1;
         end
      end
   end

   // Outputs, all registered
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         oc_q <= 4'h0;
         upd_out_q <= 1'b0;
         cmp_q <= 4'h0;
         irq_q <= 1'b0;
      end else begin
         upd_out_q <= upd_w; // [R5]
         cmp_q <= match_w; // [R6]
         irq_q <= |(sr_q & ier_q); // [R2] [R4] [R18] [R27]
         for (int i = 0; i < 4; i++) begin
            if (match_w[i]) begin
               case (ocm_q[i])
                  tcc_pkg::OCM_SET: oc_q[i] <= 1'b1; // [R17]
                  tcc_pkg::OCM_RESET: oc_q[i] <= 1'b0;
                  tcc_pkg::OCM_TOGGLE: oc_q[i] <= !oc_q[i];
                  default: oc_q[i] <= oc_q[i];
               endcase
            end else if (opm_w && upd_w) begin
               oc_q[i] <= 1'b0; // [R21]
            end
         end
      end
   end

   assign avs_waitrequest_out = wreq_q;
   assign avs_readdata_out = rdata_q;
   assign oc_out = oc_q;
   assign update_trig_out = upd_out_q;
   assign cmp_trig_out = cmp_q;
   assign irq_out = irq_q;

   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   quad_err_a: assert property (qerr_w |=> sr_q[`TCC_SR_TERR]) // [R1]
      else $error("transition error not flagged");
   terr_irq_a: assert property (sr_q[`TCC_SR_TERR] && ier_q[`TCC_SR_TERR] |=> irq_out) // [R2]
      else $error("transition error irq missing");
   idx_err_a: assert property (ierr_w |=> sr_q[`TCC_SR_IERR] ##1 irq_out || !ier_q[10]) // [R3]
      else $error("index error not flagged");
   idx_load_a: assert property (idx_en_w && idx_ev_w && !wr_cnt_w && !clr_w |=> // [R23]
      cnt_q == $past(wrap_w)) else $error("index did not load counter");
   upd_evt_a: assert property (upd_w |=> update_trig_out && sr_q[`TCC_SR_UIF]) // [R5]
      else $error("update event lost");
   cap_val_a: assert property (cap_w[0] |=> ccr_q[0] == $past(cnt_q)) // [R12]
      else $error("capture value wrong");
   ovr_flag_a: assert property (cap_w[1] && sr_q[2] |=> sr_q[6]) // [R13]
      else $error("overcapture not flagged");
   coc_clr_a: assert property (cap_w[0] && ctrl_q[`TCC_CR_COC] && !wr_cnt_w |=> // [R14]
      cnt_q == 16'h0000) else $error("counter not cleared on capture");
   filt_len_a: assert property ($rose(flt_q[0]) && filt_len_w == 4'h4 && // [R11]
      $stable(filt_len_w) |-> $past(pin_s2_q[0], 1) && $past(pin_s2_q[0], 4))
      else $error("filter accepted early");
   cmp_flag_a: assert property (match_w[2] |=> sr_q[3] && cmp_trig_out[2]) // [R18]
      else $error("compare flag missing");
   oc_set_a: assert property (match_w[0] && ocm_q[0] == tcc_pkg::OCM_SET |=> oc_out[0]) // [R17]
      else $error("compare set failed");
   cover property (qerr_w);
   cover property (cap_w[0] && sr_q[1]);
   cover property (ierr_w);
   cover property (opm_w && trg_ev_w ##[1:50] upd_w);
endmodule

// File: testbench/tcc_src_model.sv
// Purpose: Source of encoder, Hall, index, trigger and link levels
// Assumes: Pins are push-pull and always driven, never left floating
// Notes: Levels move just after a rising edge, like a clocked source
`timescale 1ns/1ns
module tcc_src_model (
   // Clock
   input wire logic clk_in,
   // Pin and link levels
   output logic [3:0] ch_out,
   output logic idx_out,
   output logic trig_out,
   output logic [3:0] link_out
);
   initial begin
      ch_out = 4'h0;
      idx_out = 1'b0;
      trig_out = 1'b0;
      link_out = 4'h0;
   end
   // Hold a channel pattern for n cycles
   task automatic put(input logic [3:0] v, input int n);
      @(posedge clk_in);
      ch_out <= v;
      repeat (n - 1) @(posedge clk_in);
   endtask
   // Line select: 0-3 channels, 4 index, 5 trigger, 8-11 link
   task automatic drive(input int which, input logic v);
      if (which < 4) begin
         ch_out[which] <= v;
      end else if (which == 4) begin
         idx_out <= v;
      end else if (which == 5) begin
         trig_out <= v;
      end else begin
         link_out[which - 8] <= v;
      end
   endtask
   // One pulse; period is hi plus lo when called back to back
   task automatic strobe(input int which, input int hi, input int lo);
      @(posedge clk_in);
      drive(which, 1'b1);
      repeat (hi) @(posedge clk_in);
      drive(which, 1'b0);
      repeat (lo - 1) @(posedge clk_in);
   endtask
endmodule

// File: testbench/tcc_top_tb.sv
// Purpose: Self-checking bench for the capture/compare block
// Assumes: One wait state per access; pins seen a few cycles late
// Notes: Period captures may read one below the period
`timescale 1ns/1ns
`include "tcc_params.svh"
module tcc_top_tb;
   // Bench signals
   logic clk;
   logic rst_n;
   logic [5:0] adr;
   logic rd;
   logic wr_en;
   logic [31:0] wdat;
   logic [3:0] be;
   logic [31:0] rdat;
   logic wait_rq;
   logic [3:0] pins;
   logic idx;
   logic trig;
   logic [3:0] link;
   logic [3:0] oc;
   logic upd;
   logic [3:0] cmp;
   logic irq;
   logic [31:0] r;
   int fails = 0;
   int tests_run = 0;
   int upd_n = 0;
   int cmp_n [4] = '{0, 0, 0, 0};
   int base [5];
   int n;
   tcc_top u_dut (
      .sys_clk_in(clk),
      .resetn_in(rst_n),
      .avs_address_in(adr),
      .avs_read_in(rd),
      .avs_write_in(wr_en),
      .avs_writedata_in(wdat),
      .avs_byteenable_in(be),
      .avs_readdata_out(rdat),
      .avs_waitrequest_out(wait_rq),
      .ch_in(pins),
      .enc_index_in(idx),
      .trig_in(trig),
      .timer_link_input_in(link),
      .oc_out(oc),
      .update_trig_out(upd),
      .cmp_trig_out(cmp),
      .irq_out(irq)
   );
   tcc_src_model u_src (
      .clk_in(clk),
      .ch_out(pins),
      .idx_out(idx),
      .trig_out(trig),
      .link_out(link)
   );
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Pulse counters; one-cycle pulses are easy to miss by polling
   always @(posedge clk) begin
      upd_n <= upd_n + int'(upd === 1'b1);
      for (int i = 0; i < 4; i++) begin
         cmp_n[i] <= cmp_n[i] + int'(cmp[i] === 1'b1);
      end
   end
   task automatic print_verdict();
      $display("Counts: %0d checks, %0d mismatches", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Slack allows one cycle less on period captures
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what,
      input bit slk = 1'b0);
      tests_run++;
      if (got !== exp && !(slk && got === exp - 1)) begin
         fails++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
      input logic [3:0] b, output logic [31:0] q);
      int k;
      @(posedge clk);
      adr <= a;
      wdat <= d;
      be <= b;
      wr_en <= w;
      rd <= !w;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wait_rq !== 1'b0 && k < 100);
      q = rdat;
      wr_en <= 1'b0;
      rd <= 1'b0;
      if (wait_rq !== 1'b0) begin
         fails++;
         $display("BAD t=%0t bus never answered", $time);
         print_verdict();
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] b = 4'hF);
      logic [31:0] q;
      bus(1'b1, a, d, b, q);
   endtask
   task automatic rdv(input logic [5:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, 4'hF, q);
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   function automatic logic [15:0] cfg(input logic cap, input logic [1:0] src,
      input logic [1:0] edg, input logic [1:0] psc, input logic [1:0] ocm, input logic cpre);
      tcc_pkg::tcc_chcfg_t c;
      c = '0;
      c.is_cap = cap;
      c.src = src;
      c.edg = edg;
      c.psc = psc;
      c.oc_mode = tcc_pkg::tcc_ocm_t'(ocm);
      c.oc_cpre = cpre;
      return c;
   endfunction
   initial begin
      rst_n = 1'b0;
      adr = 6'h00;
      rd = 1'b0;
      wr_en = 1'b0;
      wdat = 32'h0;
      be = 4'hF;
      do_reset();
      rdv(`TCC_OFF_CTRL, r);
      chk(r, `TCC_CTRL_RST, "ctrl reset");
      rdv(`TCC_OFF_SR, r);
      chk(r, 32'h0, "status reset");
      wr(6'h3C, 32'hFFFF_FFFF);
      rdv(6'h3C, r);
      chk(r, 32'h0, "unmapped");
      wr(`TCC_OFF_ARR, 32'h1234);
      wr(`TCC_OFF_ARR, 32'hAB56, 4'h1);
      rdv(`TCC_OFF_ARR, r);
      chk(r, 32'h1256, "byte lane");
      $display("registers done");
      for (int e = 0; e < 3; e++) begin
         wr(`TCC_OFF_CFG, {16'h0, cfg(1, 0, e[1:0], 0, 0, 0)});
         wr(`TCC_OFF_SR, 32'h7FF);
         u_src.put(4'h1, 10);
         rdv(`TCC_OFF_SR, r);
         chk(r[1], e != 1, "rise capture");
         wr(`TCC_OFF_SR, 32'h7FF);
         u_src.put(4'h0, 10);
         rdv(`TCC_OFF_SR, r);
         chk(r[1], e != 0, "fall capture");
      end
      wr(`TCC_OFF_CFG, {16'h0, cfg(1, 0, 0, 0, 0, 0)});
      wr(`TCC_OFF_SR, 32'h7FF);
      wr(`TCC_OFF_CNT, 32'h1234);
      u_src.strobe(0, 5, 10);
      wr(`TCC_OFF_CNT, 32'h2345);
      u_src.strobe(0, 5, 10);
      rdv(`TCC_OFF_SR, r);
      chk(r & 32'h22, 32'h22, "overcapture");
      rdv(`TCC_OFF_CCR, r);
      chk(r, 32'h2345, "captured count");
      $display("edges done");
      for (int p = 0; p < 4; p++) begin
         wr(`TCC_OFF_CFG, {16'h0, cfg(1, 0, 0, p[1:0], 0, 0)});
         n = 0;
         repeat (8) begin
            wr(`TCC_OFF_SR, 32'h7FF);
            u_src.strobe(0, 4, 6);
            rdv(`TCC_OFF_SR, r);
            n += int'(r[1] === 1'b1);
         end
         chk(n, 8 >> p, "prescaler");
      end
      wr(`TCC_OFF_CFG, {16'h0, cfg(1, 0, 0, 0, 0, 0)});
      wr(`TCC_OFF_CTRL, 32'h4000);
      wr(`TCC_OFF_SR, 32'h7FF);
      u_src.put(4'h1, 3);
      u_src.put(4'h0, 1);
      u_src.put(4'h1, 3);
      u_src.put(4'h0, 10);
      rdv(`TCC_OFF_SR, r);
      chk(r[1], 1'b0, "glitch kept out");
      u_src.put(4'h1, 4);
      u_src.put(4'h0, 10);
      rdv(`TCC_OFF_SR, r);
      chk(r[1], 1'b1, "four samples");
      $display("prescaler and filter done");
      wr(`TCC_OFF_CTRL, 32'h0001_0000);
      wr(`TCC_OFF_CFG, {cfg(1, 1, 0, 0, 0, 0), cfg(1, 2, 0, 0, 0, 0)});
      wr(`TCC_OFF_CNT, 32'h77);
      u_src.strobe(9, 2, 6);
      wr(`TCC_OFF_CNT, 32'h55);
      u_src.strobe(0, 3, 8);
      rdv(`TCC_OFF_CCR, r);
      chk(r, 32'h77, "link capture");
      rdv(6'h20, r);
      chk(r, 32'h55, "neighbour capture");
      $display("sources done");
      do_reset();
      wr(`TCC_OFF_CFG, {cfg(1, 0, 0, 0, 0, 0), cfg(1, 0, 0, 0, 0, 0)});
      wr(`TCC_OFF_CTRL, 32'h81);
      repeat (3) u_src.strobe(0, 20, 20);
      rdv(`TCC_OFF_CCR, r);
      chk(r, 32'd40, "clear on capture", 1'b1);
      wr(`TCC_OFF_CTRL, 32'h401);
      repeat (3) u_src.strobe(0, 15, 25);
      rdv(6'h20, r);
      chk(r, 32'd40, "pwm period", 1'b1);
      rdv(`TCC_OFF_CCR, r);
      chk(r, 32'd15, "pwm width", 1'b1);
      wr(`TCC_OFF_CTRL, 32'h41);
      u_src.put(4'h1, 30);
      u_src.put(4'h3, 17);
      u_src.put(4'h7, 10);
      rdv(`TCC_OFF_CCR, r);
      chk(r, 32'd17, "xor interval", 1'b1);
      u_src.put(4'h0, 1);
      $display("advanced capture done");
      do_reset();
      wr(`TCC_OFF_ARR, 32'h30);
      wr(`TCC_OFF_CFG, {cfg(0, 0, 0, 0, 1, 0), cfg(0, 0, 0, 0, 3, 0)});
      wr(6'h18, {cfg(0, 0, 0, 0, 2, 0), cfg(0, 0, 0, 0, 0, 0)});
      for (int c = 0; c < 4; c++) begin
         wr(`TCC_OFF_CCR + 6'(4 * c), 32'h10 + 32'(8 * c));
         base[c] = cmp_n[c];
      end
      base[4] = upd_n;
      wr(`TCC_OFF_IER, 32'h4);
      wr(`TCC_OFF_CTRL, 32'h1);
      repeat (44) @(posedge clk);
      wr(`TCC_OFF_CTRL, 32'h0);
      chk(oc, 4'b0011, "compare outputs");
      rdv(`TCC_OFF_SR, r);
      chk(r & 32'h1F, 32'h1E, "compare flags");
      chk(irq, 1'b1, "compare irq");
      for (int c = 0; c < 4; c++) begin
         chk(cmp_n[c] - base[c], 1, "compare pulse");
      end
      wr(`TCC_OFF_SR, 32'h4);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0, "masked flags");
      rdv(`TCC_OFF_SR, r);
      chk(r & 32'h1F, 32'h1A, "sticky flags");
      wr(`TCC_OFF_CFG, {cfg(0, 0, 0, 0, 1, 1), cfg(0, 0, 0, 0, 3, 0)});
      wr(6'h20, 32'h05);
      wr(`TCC_OFF_CCR, 32'h22);
      rdv(`TCC_OFF_CCR, r);
      chk(r, 32'h22, "direct compare");
      rdv(6'h20, r);
      chk(r, 32'h18, "held compare");
      wr(`TCC_OFF_CTRL, 32'h1);
      repeat (20) @(posedge clk);
      wr(`TCC_OFF_CTRL, 32'h0);
      rdv(6'h20, r);
      chk(r, 32'h05, "loaded compare");
      chk(upd_n - base[4], 1, "update pulse");
      rdv(`TCC_OFF_SR, r);
      chk(r[0], 1'b1, "update flag");
      $display("compare done");
      do_reset();
      wr(`TCC_OFF_IER, 32'h600);
      wr(`TCC_OFF_CTRL, 32'h100);
      u_src.put(4'h0, 3);
      u_src.put(4'h1, 3);
      u_src.put(4'h3, 3);
      u_src.put(4'h2, 3);
      u_src.put(4'h0, 3);
      u_src.put(4'h1, 3);
      rdv(`TCC_OFF_SR, r);
      chk(r[9], 1'b0, "legal steps");
      u_src.put(4'h2, 6);
      rdv(`TCC_OFF_SR, r);
      chk(r[9], 1'b1, "double step");
      chk(irq, 1'b1, "step irq");
      wr(`TCC_OFF_SR, 32'h200);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0, "step cleared");
      wr(`TCC_OFF_ARR, 32'h20);
      wr(`TCC_OFF_CTRL, 32'h201);
      repeat (80) @(posedge clk);
      rdv(`TCC_OFF_SR, r);
      chk(r[10], 1'b1, "no index");
      chk(irq, 1'b1, "index irq");
      wr(`TCC_OFF_CTRL, 32'h0);
      wr(`TCC_OFF_CNT, 32'h0);
      wr(`TCC_OFF_SR, 32'h7FF);
      fork
         wr(`TCC_OFF_CTRL, 32'h201);
         repeat (12) u_src.strobe(4, 2, 10);
      join
      rdv(`TCC_OFF_SR, r);
      chk(r & 32'h401, 32'h0, "index in time");
      $display("encoder done");
      do_reset();
      wr(`TCC_OFF_ARR, 32'h30);
      wr(`TCC_OFF_CFG, {16'h0, cfg(0, 0, 0, 0, 1, 0)});
      wr(`TCC_OFF_CCR, 32'h10);
      wr(`TCC_OFF_CTRL, 32'h18);
      u_src.strobe(5, 2, 30);
      chk(oc[0], 1'b1, "pulse started");
      u_src.strobe(5, 2, 30);
      chk(oc[0], 1'b1, "pulse extended");
      repeat (40) @(posedge clk);
      chk(oc[0], 1'b0, "pulse ended");
      rdv(`TCC_OFF_CTRL, r);
      chk(r[0], 1'b0, "counter stopped");
      $display("one pulse done");
      print_verdict();
   end
endmodule
